// ### pkg/cvt_defines.svh
// offsets, field positions, reset values and counts of the trim register bank
`ifndef CVT_DEFINES_SVH
`define CVT_DEFINES_SVH

`define CVT_ADDR_W        12
`define CVT_OFS_VEC_EN    12'h070
`define CVT_OFS_VEC_PORT  12'h071
`define CVT_OFS_GAIN_A    12'h07a
`define CVT_OFS_GAIN_B    12'h07b
`define CVT_OFS_BANDGAP   12'h07c
`define CVT_OFS_TERM_A    12'h07e
`define CVT_OFS_TERM_B    12'h07f

`define CVT_EN_BIT        0
`define CVT_BG_MSB        3
`define CVT_RST_VEC_EN    8'h00
`define CVT_RST_TRIM      8'h00
`define CVT_RST_BG        4'h0
`define CVT_RDATA_NONE    8'h00

`define CVT_VEC_LEN       673
`define CVT_IDX_W         10
`define CVT_FIFO_DEPTH    8

`endif

// ### pkg/cvt_pkg.sv
// types shared by the trim register bank and its vector buffer
`default_nettype none
package cvt_pkg;
`include "cvt_defines.svh"

    typedef struct packed {
        logic                   rd;
        logic                   wr;
        logic [`CVT_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
    } cvt_req_t;

    typedef struct packed {
        logic [7:0] gain_a;
        logic [7:0] gain_b;
        logic [3:0] bandgap;
        logic [7:0] term_a;
        logic [7:0] term_b;
    } cvt_trim_t;

    typedef struct packed {
        logic [`CVT_IDX_W-1:0] index;
        logic [7:0]            data;
    } cvt_vec_t;

endpackage : cvt_pkg
`default_nettype wire

// ### hdl/cvt_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cvt_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  empty
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PW-1:0]    wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [CW-1:0]    cnt_reg, cnt_next;
    logic             push, pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        if (32'(p) == DEPTH - 1) begin
            return '0;
        end
        return p + 1'b1;
    endfunction : bump

    assign in_ready  = (32'(cnt_reg) < DEPTH);
    assign out_valid = (cnt_reg != '0);
    assign empty     = (cnt_reg == '0);
    assign out_data  = mem_reg[rptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        mem_next  = mem_reg;
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        cnt_next  = cnt_reg;
        if (push) begin
            mem_next[wptr_reg] = in_data;
            wptr_next          = bump(wptr_reg);
        end
        if (pop) begin
            rptr_next = bump(rptr_reg);
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end else begin
            mem_reg  <= mem_next;
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg  <= cnt_next;
        end
    end
endmodule : cvt_fifo
`default_nettype wire

// ### hdl/cvt_regs.sv
// calibration vector port and factory trim registers
`timescale 1ns/1ps
`default_nettype none
`include "cvt_defines.svh"

// Contract
// RL1: bit 0 of the access enable register gates every port access.
// RL2: with access on, each port read returns the next vector byte.
// RL3: with access on, each port write loads the next vector byte.
// RL4: the host may stream all port accesses at one held address.
// RL5: the host must not touch the port while calibration still runs; not enforced, access proceeds and only sets vec_access_while_running.
// RL6: the host must complete each transfer with the full access count.
// RL7: two 8-bit gain adjust registers, one per input, read and write.
// RL8: bandgap adjust holds 4 bits in 3:0, upper bits reserved.
// RL9: two 8-bit termination adjust registers, one per input.
// RL10: the port's content after reset is undefined.
// RL11: trim registers load the factory fuse values after reset.
// RL12: the vector position restarts at byte 0 when access is enabled.
module cvt_regs
    import cvt_pkg::*;
#(
    parameter int VEC_LEN    = `CVT_VEC_LEN,
    parameter int FIFO_DEPTH = `CVT_FIFO_DEPTH
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire cvt_req_t              req,
    output logic                       req_ready,
    output logic                       rvalid,
    output logic [7:0]                 rdata,
    input  wire cvt_trim_t             fuse_trim,
    output cvt_trim_t                  trim,
    output logic                       vec_access_on,
    output logic [`CVT_IDX_W-1:0]      vec_rd_index,
    input  wire logic [7:0]            vec_rd_data,
    output logic                       vec_wr_valid,
    input  wire logic                  vec_wr_ready,
    output cvt_vec_t                   vec_wr,
    input  wire logic                  calibration_halted_flag,
    output logic                       vec_access_while_running
);
    localparam int FW = $bits(cvt_vec_t);

    logic                  en_reg, en_next;
    cvt_trim_t             trim_reg, trim_next;
    logic                  load_reg, load_next;
    logic [`CVT_IDX_W-1:0] idx_reg, idx_next;
    logic [7:0]            rdata_reg, rdata_next;
    logic                  rvalid_reg, rvalid_next;
    logic                  run_err_reg, run_err_next;

    logic     port_hit, port_rd, port_wr;
    logic     fifo_in_valid, fifo_in_ready, fifo_empty;
    cvt_vec_t fifo_in;
    logic [FW-1:0] fifo_out;

    function automatic logic [`CVT_IDX_W-1:0] next_index(
        input logic [`CVT_IDX_W-1:0] i
    );
        if (32'(i) >= VEC_LEN - 1) begin
            return '0;
        end
        return i + 1'b1;
    endfunction : next_index

    // rl1 port gated by enable bit
    assign port_hit = en_reg && (req.addr == `CVT_OFS_VEC_PORT);
    assign port_rd  = port_hit && req.rd;
    assign port_wr  = port_hit && req.wr && !req.rd;

    // reads wait for queued writes so the vector stays in byte order;
    // writes wait for buffer room, which is the back-pressure to the host
    assign req_ready = !load_reg
                       && !(port_rd && !fifo_empty)
                       && !(port_wr && !fifo_in_ready);

    assign fifo_in.index = idx_reg;
    assign fifo_in.data  = req.wdata;
    assign fifo_in_valid = port_wr && !load_reg;

    always_comb begin
        en_next      = en_reg;
        trim_next    = trim_reg;
        load_next    = 1'b0;
        idx_next     = idx_reg;
        rdata_next   = rdata_reg;
        rvalid_next  = 1'b0;
        run_err_next = run_err_reg;
        if (load_reg) begin
            // rl11 fuse values loaded once after reset
            trim_next = fuse_trim;
        end else if (req_ready && (req.rd || req.wr)) begin
            if (!en_reg && req.wr && !req.rd
                && req.addr == `CVT_OFS_VEC_EN
                && req.wdata[`CVT_EN_BIT]) begin
                // rl12 restart at first byte
                idx_next = '0;
            end
            if (port_hit && !calibration_halted_flag) begin
                run_err_next = 1'b1;
            end
            if (req.rd) begin
                rvalid_next = 1'b1;
                case (req.addr)
                    `CVT_OFS_VEC_EN: begin
                        rdata_next = {7'h00, en_reg};
                    end
                    `CVT_OFS_VEC_PORT: begin
                        if (en_reg) begin
                            // rl2 read returns next byte
                            // rl10 engine byte, no reset value
                            rdata_next = vec_rd_data;
                            idx_next   = next_index(idx_reg);
                        end else begin
                            rdata_next = `CVT_RDATA_NONE;
                        end
                    end
                    `CVT_OFS_GAIN_A:  rdata_next = trim_reg.gain_a;
                    `CVT_OFS_GAIN_B:  rdata_next = trim_reg.gain_b;
                    // rl8 reserved upper bits read zero
                    `CVT_OFS_BANDGAP: rdata_next = {4'h0, trim_reg.bandgap};
                    `CVT_OFS_TERM_A:  rdata_next = trim_reg.term_a;
                    `CVT_OFS_TERM_B:  rdata_next = trim_reg.term_b;
                    default:          rdata_next = `CVT_RDATA_NONE;
                endcase
            end else begin
                case (req.addr)
                    `CVT_OFS_VEC_EN: begin
                        en_next = req.wdata[`CVT_EN_BIT];
                    end
                    `CVT_OFS_VEC_PORT: begin
                        if (en_reg) begin
                            // rl3 write loads next byte
                            idx_next = next_index(idx_reg);
                        end
                    end
                    // rl7 gain adjust per input
                    `CVT_OFS_GAIN_A:  trim_next.gain_a = req.wdata;
                    `CVT_OFS_GAIN_B:  trim_next.gain_b = req.wdata;
                    // rl8 only the 4-bit field stored
                    `CVT_OFS_BANDGAP: begin
                        trim_next.bandgap = req.wdata[`CVT_BG_MSB:0];
                    end
                    // rl9 termination adjust per input
                    `CVT_OFS_TERM_A:  trim_next.term_a = req.wdata;
                    `CVT_OFS_TERM_B:  trim_next.term_b = req.wdata;
                    default: begin
                        en_next = en_reg;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg      <= 1'b0;
            trim_reg    <= '0;
            // async reset cannot take port values; fuses load next edge
            load_reg    <= 1'b1;
            idx_reg     <= '0;
            rdata_reg   <= `CVT_RDATA_NONE;
            rvalid_reg  <= 1'b0;
            run_err_reg <= 1'b0;
        end else begin
            en_reg      <= en_next;
            trim_reg    <= trim_next;
            load_reg    <= load_next;
            idx_reg     <= idx_next;
            rdata_reg   <= rdata_next;
            rvalid_reg  <= rvalid_next;
            run_err_reg <= run_err_next;
        end
    end

    cvt_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_vec_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (vec_wr_valid),
        .out_ready (vec_wr_ready),
        .out_data  (fifo_out),
        .empty     (fifo_empty)
    );

    assign vec_wr                   = cvt_vec_t'(fifo_out);
    assign rvalid                   = rvalid_reg;
    assign rdata                    = rdata_reg;
    assign trim                     = trim_reg;
    assign vec_access_on            = en_reg;
    assign vec_rd_index             = idx_reg;
    // sticky hint only; access is not blocked, the engine decides
    assign vec_access_while_running = run_err_reg;
endmodule : cvt_regs
`default_nettype wire

// ### tb/cvt_regs_chk.sv
// concurrent checks on the trim bank ports
`timescale 1ns/1ps
`default_nettype none
module cvt_regs_chk
    import cvt_pkg::*;
#(
    parameter int VEC_LEN = 673
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire cvt_req_t   req,
    input wire logic       req_ready,
    input wire logic       rvalid,
    input wire logic [7:0] rdata,
    input wire cvt_trim_t  fuse_trim,
    input wire cvt_trim_t  trim,
    input wire logic       vec_access_on,
    input wire logic [9:0] vec_rd_index,
    input wire logic       calibration_halted_flag,
    input wire logic       vec_access_while_running
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rt;
    logic wt;
    logic pt;
    assign rt = req.rd && req_ready;
    assign wt = req.wr && !req.rd && req_ready;
    assign pt = (rt || wt) && req.addr == 12'h071;
    a_read_answer: assert property (rt |=> rvalid)
        else $error("read got no answer");
    a_port_gated: assert property (
        rt && req.addr == 12'h071 && !vec_access_on |=> rdata == 8'h00
    ) else $error("disabled port gave data");
    a_enable_bit: assert property (
        wt && req.addr == 12'h070 |=> vec_access_on == $past(req.wdata[0])
    ) else $error("enable bit not stored");
    a_index_step: assert property (
        pt && vec_access_on |=> vec_rd_index ==
            ($past(vec_rd_index) == VEC_LEN - 1 ? 10'h000
                : $past(vec_rd_index) + 10'h001)
    ) else $error("vector index did not step");
    a_bandgap_write: assert property (
        wt && req.addr == 12'h07c |=> trim.bandgap == $past(req.wdata[3:0])
    ) else $error("bandgap not written");
    a_gain_write: assert property (
        wt && req.addr == 12'h07b |=> trim.gain_b == $past(req.wdata)
    ) else $error("gain b not written");
    a_fuse_load: assert property (
        !$past(rst_n) |=> trim == $past(fuse_trim)
    ) else $error("trim not loaded from fuses");
    a_sticky_misuse: assert property (
        pt && vec_access_on && !calibration_halted_flag
            |=> vec_access_while_running
    ) else $error("misuse flag not set");
endmodule : cvt_regs_chk

bind cvt_regs cvt_regs_chk #(.VEC_LEN(VEC_LEN)) u_chk (
    .clk(clk), .rst_n(rst_n), .req(req), .req_ready(req_ready),
    .rvalid(rvalid), .rdata(rdata), .fuse_trim(fuse_trim), .trim(trim),
    .vec_access_on(vec_access_on), .vec_rd_index(vec_rd_index),
    .calibration_halted_flag(calibration_halted_flag),
    .vec_access_while_running(vec_access_while_running)
);
`default_nettype wire

// ### tb/cvt_regs_tb_top.sv
// self-checking bench for the trim register bank
`timescale 1ns/1ps
`default_nettype none
module cvt_regs_tb_top
    import cvt_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       halted = 1'b1;
    logic       stall = 1'b0;
    logic       vec_wr_ready = 1'b0;
    logic       req_ready, rvalid, vec_wr_valid, misuse;
    logic [7:0] rdata, vec_rd_data;
    logic [9:0] vec_rd_index;
    cvt_req_t   req = '0;
    cvt_trim_t  fuse_trim;
    cvt_vec_t   vec_wr;
    int         err_count = 0, n_compared = 0, last_wait;
    logic [7:0] rq[$];
    cvt_vec_t   wq[$];
    always #12.5 clk = ~clk;
    // engine stub: each stored byte is a pattern of its index
    assign vec_rd_data = vec_rd_index[7:0] ^ 8'ha5;
    always @(posedge clk) vec_wr_ready <= !stall && 1'($urandom);
    cvt_regs dut (
        .clk(clk), .rst_n(rst_n), .req(req), .req_ready(req_ready),
        .rvalid(rvalid), .rdata(rdata), .fuse_trim(fuse_trim), .trim(),
        .vec_access_on(), .vec_rd_index(vec_rd_index),
        .vec_rd_data(vec_rd_data), .vec_wr_valid(vec_wr_valid),
        .vec_wr_ready(vec_wr_ready), .vec_wr(vec_wr),
        .calibration_halted_flag(halted),
        .vec_access_while_running(misuse)
    );
    task automatic chk(input logic [35:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // request stands until taken; reads note d as the expected byte
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        req <= '{rd: !w, wr: w, addr: a, wdata: d};
        last_wait = 0;
        // ready settles mid-cycle; look there, then let the taking edge pass
        @(negedge clk);
        while (req_ready !== 1'b1 && last_wait < 500) begin
            @(negedge clk);
            last_wait++;
        end
        @(posedge clk);
        if (last_wait >= 500) begin
            err_count++;
            give_verdict();
        end
        if (!w) rq.push_back(d);
    endtask : acc
    always @(posedge clk) begin
        if (rvalid === 1'b1)
            chk(rdata, rq.pop_front(), "rdata");
        if (vec_wr_valid === 1'b1 && vec_wr_ready === 1'b1)
            chk(vec_wr, wq.pop_front(), "vec_wr");
    end
    initial begin
        logic [63:0] r;
        logic [11:0] ta[5];
        logic [7:0]  fv[5], d;
        void'($urandom(6));
        r = {$urandom, $urandom};
        fuse_trim = r[35:0];
        ta = '{12'h07a, 12'h07b, 12'h07c, 12'h07e, 12'h07f};
        fv = '{r[35:28], r[27:20], {4'h0, r[19:16]}, r[15:8], r[7:0]};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, ta[i], fv[i]);
            d = 8'($urandom);
            acc(1'b1, ta[i], d);
            acc(1'b0, ta[i], ta[i] == 12'h07c ? d & 8'h0f : d);
        end
        acc(1'b0, 12'h07d, 8'h00);
        acc(1'b0, 12'h071, 8'h00);
        acc(1'b1, 12'h070, 8'hff);
        acc(1'b0, 12'h070, 8'h01);
        for (int k = 0; k < 5; k++) acc(1'b0, 12'h071, 8'(k) ^ 8'ha5);
        acc(1'b1, 12'h070, 8'h00);
        acc(1'b1, 12'h070, 8'h01);
        // restart from byte 0; whole vector at one address
        // this transfer runs the full 673 accesses; the first one above stopped after 5
        for (int k = 0; k < 673; k++) acc(1'b0, 12'h071, 8'(k) ^ 8'ha5);
        acc(1'b0, 12'h071, 8'ha5);
        stall <= 1'b1;
        acc(1'b1, 12'h070, 8'h00);
        acc(1'b1, 12'h070, 8'h01);
        fork
            begin
                repeat (40) @(posedge clk);
                stall <= 1'b0;
            end
        join_none
        for (int k = 0; k < 673; k++) begin
            d = 8'($urandom);
            wq.push_back({10'(k), d});
            acc(1'b1, 12'h071, d);
            if (k == 8) chk(last_wait > 0, 1'b1, "full");
        end
        req <= '0;
        for (int n = 0; n < 5000 && wq.size() > 0; n++) @(posedge clk);
        chk(wq.size(), 0, "drained");
        chk(misuse, 1'b0, "misuse");
        halted <= 1'b0;
        acc(1'b0, 12'h071, 8'ha5);
        req <= '0;
        repeat (2) @(posedge clk);
        chk(misuse, 1'b1, "misuse");
        give_verdict();
    end
endmodule : cvt_regs_tb_top
`default_nettype wire
